/* File: hdl/uart_host_regs.sv */
// Character FIFO and the host register block of one UART channel.
// Assumes synchronous host strobes and a transmitter and receiver on core_clk.
`timescale 1ns/1ns
`default_nettype none
module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("char_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [LW-1:0] cnt_ff;
    logic push;
    logic pop;
    assign in_ready = cnt_ff != LW'(DEPTH);
    assign out_valid = cnt_ff != '0;
    assign out_data = mem[rd_ptr_ff];
    assign level = cnt_ff;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else if (flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + AW'(push);
            rd_ptr_ff <= rd_ptr_ff + AW'(pop);
            cnt_ff <= cnt_ff + LW'(push) - LW'(pop);
        end
    end
endmodule : char_fifo

module uart_host_regs
    import uart_regs_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter logic [7:0] REV_CODE = 8'h01,
    parameter logic [7:0] DEV_CODE = 8'h5c
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Host bus
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic int_out,
    // Receiver
    input wire logic rx_valid,
    input wire rx_char_t rx_char,
    // Transmitter
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic tx_shift_busy,
    // Modem lines
    input wire logic [3:0] modem_delta,
    input wire logic [3:0] modem_lines
);
    // DEV_CODE and REV_CODE defaults are arbitrary.
    localparam int LW = $clog2(DEPTH+1);
    if (DEPTH > 255) begin : g_chk
        $error("level must fit one byte");
    end
    // -------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------
    function automatic sel_t reg_sel(input logic [2:0] a, input logic [7:0] line_control,
        input logic swap);
        reg_sel = SEL_NONE;
        if (line_control == LCR_ENH_KEY) begin
            case (a)
                ADR_TRG: reg_sel = SEL_TRG;
                ADR_FEATURE_CONTROL: reg_sel = SEL_FEATURE_CONTROL;
                ADR_EFR: reg_sel = SEL_EFR;
                ADR_LCR: reg_sel = SEL_LCR;
                default: reg_sel = a[2] ? SEL_FLOW : SEL_NONE;
            endcase
        end else if (line_control[LCR_DLAB] && a < ADR_LCR) begin
            case (a)
                ADR_DATA: reg_sel = SEL_DLL;
                ADR_IRQEN: reg_sel = SEL_DLM;
                default: reg_sel = SEL_DLD;
            endcase
        end else begin
            case (a)
                ADR_DATA: reg_sel = SEL_DATA;
                ADR_IRQEN: reg_sel = SEL_IRQEN;
                ADR_ISR: reg_sel = SEL_ISR;
                ADR_LCR: reg_sel = SEL_LCR;
                ADR_MCR: reg_sel = SEL_MCR;
                ADR_LSR: reg_sel = SEL_LSR;
                ADR_MSR: reg_sel = SEL_MSR;
                default: reg_sel = swap ? SEL_ALT7 : SEL_SPR;
            endcase
        end
    endfunction : reg_sel

    function automatic logic [7:0] trig_of(input logic [1:0] s);
        case (s)
            2'h0: trig_of = TRIG_L0;
            2'h1: trig_of = TRIG_L1;
            2'h2: trig_of = TRIG_L2;
            default: trig_of = TRIG_L3;
        endcase
    endfunction : trig_of

    logic rd_n_q_ff, wr_n_q_ff;
    logic [7:0] lcr_ff, ier_ff, mcr_ff, spr_ff, dll_ff, dlm_ff, efr_ff, feature_control_ff;
    logic [7:0] trg_ff, enhanced_mode_select_ff;
    logic [3:0] dld_ff;
    logic [7:0] flow_ch_ff [0:3];
    logic fifo_en_ff;
    logic [1:0] rx_sel_ff, tx_sel_ff;
    logic rd_stb, wr_stb, enh;
    sel_t sel;
    assign rd_stb = !cs_n && !rd_n && rd_n_q_ff;
    assign wr_stb = !cs_n && !wr_n && wr_n_q_ff;
    assign sel = reg_sel(addr, lcr_ff, feature_control_ff[FEATURE_CONTROL_SWAP]);
    assign enh = efr_ff[EFR_ENH];
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_n_q_ff <= 1'b1;
            wr_n_q_ff <= 1'b1;
        end else begin
            rd_n_q_ff <= rd_n;
            wr_n_q_ff <= wr_n;
        end
    end
    // -------------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------------
    logic fcr_wr, rx_flush, tx_flush;
    assign fcr_wr = wr_stb && sel == SEL_ISR;
    // The reset bits only act while the same write keeps the FIFOs enabled.
    assign rx_flush = fcr_wr && ((data_in[FCR_EN] && data_in[FCR_RXRST]) ||
        data_in[FCR_EN] != fifo_en_ff);
    assign tx_flush = fcr_wr && ((data_in[FCR_EN] && data_in[FCR_TXRST]) ||
        data_in[FCR_EN] != fifo_en_ff);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lcr_ff <= RST_BYTE;
            ier_ff <= RST_BYTE;
            mcr_ff <= RST_BYTE;
            spr_ff <= RST_BYTE;
            dll_ff <= RST_BYTE;
            dlm_ff <= RST_BYTE;
            efr_ff <= RST_BYTE;
            feature_control_ff <= RST_BYTE;
            trg_ff <= RST_BYTE;
            enhanced_mode_select_ff <= RST_BYTE;
            dld_ff <= 4'h0;
            fifo_en_ff <= 1'b0;
            rx_sel_ff <= 2'h0;
            tx_sel_ff <= 2'h0;
            for (int i = 0; i < 4; i++) begin
                flow_ch_ff[i] <= RST_BYTE;
            end
        end else if (wr_stb) begin
            case (sel)
                SEL_IRQEN: ier_ff <= enh ? data_in : {ier_ff[7:4], data_in[3:0]};
                SEL_ISR: begin
                    fifo_en_ff <= data_in[FCR_EN];
                    if (data_in[FCR_EN]) begin
                        rx_sel_ff <= data_in[7:6];
                        tx_sel_ff <= enh ? data_in[5:4] : tx_sel_ff;
                    end
                end
                SEL_LCR: lcr_ff <= data_in;
                SEL_MCR: mcr_ff <= enh ? data_in : {mcr_ff[7:5], data_in[4:0]};
                SEL_SPR: spr_ff <= data_in;
                SEL_ALT7: enhanced_mode_select_ff <= data_in;
                SEL_DLL: dll_ff <= data_in;
                SEL_DLM: dlm_ff <= data_in;
                SEL_DLD: dld_ff <= enh ? data_in[3:0] : dld_ff;
                SEL_TRG: trg_ff <= data_in;
                SEL_FEATURE_CONTROL: feature_control_ff <= data_in;
                SEL_EFR: efr_ff <= data_in;
                SEL_FLOW: flow_ch_ff[addr[1:0]] <= data_in;
                default: ;
            endcase
        end
    end
    // -------------------------------------------------------------------
    // Receive and transmit FIFOs
    // -------------------------------------------------------------------
    logic rx_in_ok, rx_push, rx_pop, rx_out_valid, rx_rdy, rx_overrun;
    logic tx_push, tx_in_rdy, tx_out_valid, tx_drain;
    logic [7:0] tx_out;
    rx_char_t rx_head;
    logic [LW-1:0] rx_level, tx_level;
    logic [7:0] rx_lvl8, tx_lvl8, rx_trig, tx_trig;
    logic prog_trg;
    assign rx_lvl8 = 8'(rx_level);
    assign tx_lvl8 = 8'(tx_level);
    // Without FIFOs each side holds a single character.
    assign rx_in_ok = fifo_en_ff || rx_level == '0;
    assign rx_push = rx_valid && rx_in_ok && rx_rdy;
    assign rx_overrun = rx_valid && !rx_push;
    assign rx_pop = rd_stb && sel == SEL_DATA && rx_out_valid;
    assign tx_push = wr_stb && sel == SEL_DATA && (fifo_en_ff || tx_level == '0);
    assign tx_drain = !tx_valid || tx_ready;
    assign prog_trg = feature_control_ff[5:4] == 2'h3;
    assign rx_trig = (prog_trg && feature_control_ff[FEATURE_CONTROL_MODE] && trg_ff != 8'h00) ?
        trg_ff : trig_of(rx_sel_ff);
    assign tx_trig = (prog_trg && !feature_control_ff[FEATURE_CONTROL_MODE] && trg_ff != 8'h00) ?
        trg_ff : trig_of(enh ? tx_sel_ff : 2'h0);
    char_fifo #(.WIDTH(11), .DEPTH(DEPTH)) u_rx_fifo (
        .clk(core_clk),
        .nrst(nrst),
        .flush(rx_flush),
        .in_valid(rx_valid && rx_in_ok),
        .in_data(rx_char),
        .in_ready(rx_rdy),
        .out_valid(rx_out_valid),
        .out_data(rx_head),
        .out_ready(rx_pop),
        .level(rx_level)
    );
    char_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .clk(core_clk),
        .nrst(nrst),
        .flush(tx_flush),
        .in_valid(tx_push),
        .in_data(data_in),
        .in_ready(tx_in_rdy),
        .out_valid(tx_out_valid),
        .out_data(tx_out),
        .out_ready(tx_drain),
        .level(tx_level)
    );
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_valid <= 1'b0;
            tx_data <= RST_BYTE;
        end else if (tx_drain) begin
            tx_valid <= tx_out_valid;
            tx_data <= tx_out;
        end
    end
    // -------------------------------------------------------------------
    // Line status
    // -------------------------------------------------------------------
    logic overrun_ff, lsr_evt_ff, lsr_rd, push_err, pop_err, head_err;
    logic [LW-1:0] err_cnt_ff;
    logic [7:0] lsr_val;
    assign lsr_rd = rd_stb && sel == SEL_LSR;
    assign push_err = rx_push && (rx_char.brk || rx_char.frm || rx_char.par);
    assign head_err = rx_head.brk || rx_head.frm || rx_head.par;
    assign pop_err = rx_pop && head_err;
    // Bits 0, 5 and 6 let the host poll each side on its own.
    assign lsr_val = {err_cnt_ff != '0,
        tx_level == '0 && !tx_valid && !tx_shift_busy, tx_level == '0,
        rx_out_valid ? {rx_head.brk, rx_head.frm, rx_head.par} : 3'h0,
        overrun_ff, rx_out_valid};
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            err_cnt_ff <= '0;
        end else if (rx_flush) begin
            err_cnt_ff <= '0;
        end else begin
            err_cnt_ff <= err_cnt_ff + LW'(push_err) - LW'(pop_err);
        end
    end
    // A new error in the clearing cycle keeps its flag.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            overrun_ff <= 1'b0;
            lsr_evt_ff <= 1'b0;
        end else begin
            overrun_ff <= (overrun_ff && !lsr_rd) || rx_overrun;
            lsr_evt_ff <= (lsr_evt_ff && !lsr_rd) ||
                (enhanced_mode_select_ff[ENHANCED_MODE_SELECT_IMM] ? push_err : pop_err);
        end
    end
    // -------------------------------------------------------------------
    // Baud tick and receive timeout
    // -------------------------------------------------------------------
    logic [19:0] baud_cnt_ff, baud_period;
    logic bit_tick_ff;
    logic [5:0] tout_cnt_ff, tout_limit, frame_bits;
    assign baud_period = 20'({dlm_ff, dll_ff}) * BAUD_OVERSAMPLE;
    // A character time counts start, five to eight data bits, parity and stop bits.
    assign frame_bits = 6'h07 + 6'(lcr_ff[1:0]) + 6'(lcr_ff[3]) + 6'(lcr_ff[2]);
    assign tout_limit = 6'(TOUT_CHARS * frame_bits) + TOUT_BITS;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            baud_cnt_ff <= 20'h00000;
            bit_tick_ff <= 1'b0;
        end else begin
            bit_tick_ff <= baud_period != 20'h00000 && baud_cnt_ff >= baud_period - 20'h00001;
            if (baud_period == 20'h00000 || baud_cnt_ff >= baud_period - 20'h00001) begin
                baud_cnt_ff <= 20'h00000;
            end else begin
                baud_cnt_ff <= baud_cnt_ff + 20'h00001;
            end
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tout_cnt_ff <= 6'h00;
        end else if (rx_push || rx_pop || rx_level == '0 || !fifo_en_ff) begin
            tout_cnt_ff <= 6'h00;
        end else if (bit_tick_ff && tout_cnt_ff < tout_limit) begin
            tout_cnt_ff <= tout_cnt_ff + 6'h01;
        end
    end
    // -------------------------------------------------------------------
    // Interrupt sources
    // -------------------------------------------------------------------
    logic rx_cond, tx_cond, tx_cond_q_ff, tx_irq_ff, tx_arm, tx_clr, isr_rd;
    logic tout_cond;
    logic [3:0] msr_delta_ff;
    logic [4:0] pend;
    logic [5:0] isr_code;
    assign rx_cond = fifo_en_ff ? rx_lvl8 >= rx_trig : rx_out_valid;
    assign tx_cond = fifo_en_ff ? tx_lvl8 < tx_trig : tx_level == '0;
    assign tout_cond = fifo_en_ff && rx_level != '0 && tout_cnt_ff >= tout_limit;
    assign tx_arm = wr_stb && sel == SEL_IRQEN && data_in[1] && !ier_ff[1];
    assign isr_rd = rd_stb && sel == SEL_ISR;
    assign tx_clr = tx_push || (isr_rd && isr_code == ISR_TXRDY);
    // Each source is masked by an enable bit; receive data and timeout share bit 0.
    assign pend = {ier_ff[2] && (overrun_ff || lsr_evt_ff),
        ier_ff[0] && tout_cond, ier_ff[0] && rx_cond,
        ier_ff[1] && tx_irq_ff, ier_ff[3] && msr_delta_ff != 4'h0};
    always_comb begin
        isr_code = ISR_NONE;
        if (pend[4]) begin
            isr_code = ISR_LINE;
        end else if (pend[3]) begin
            isr_code = ISR_TOUT;
        end else if (pend[2]) begin
            isr_code = ISR_RX_DATA_READY_IRQ;
        end else if (pend[1]) begin
            isr_code = ISR_TXRDY;
        end else if (pend[0]) begin
            isr_code = ISR_MODEM;
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_cond_q_ff <= 1'b1;
            tx_irq_ff <= 1'b0;
            msr_delta_ff <= 4'h0;
            int_out <= 1'b0;
        end else begin
            tx_cond_q_ff <= tx_cond;
            tx_irq_ff <= (tx_irq_ff && !tx_clr) ||
                (tx_cond && (!tx_cond_q_ff || tx_arm));
            msr_delta_ff <= (rd_stb && sel == SEL_MSR ? 4'h0 : msr_delta_ff) |
                modem_delta;
            int_out <= pend != 5'h00;
        end
    end
    // -------------------------------------------------------------------
    // Register reads
    // -------------------------------------------------------------------
    logic [7:0] rd_val;
    logic div_zero;
    assign div_zero = dll_ff == 8'h00 && dlm_ff == 8'h00;
    always_comb begin
        rd_val = 8'h00;
        case (sel)
            SEL_DATA: rd_val = rx_head.data;
            SEL_IRQEN: rd_val = enh ? ier_ff : {4'h0, ier_ff[3:0]};
            SEL_ISR: rd_val = {fifo_en_ff, fifo_en_ff, isr_code};
            SEL_LCR: rd_val = lcr_ff;
            SEL_MCR: rd_val = mcr_ff;
            SEL_LSR: rd_val = lsr_val;
            SEL_MSR: rd_val = {modem_lines, msr_delta_ff};
            SEL_SPR: rd_val = spr_ff;
            SEL_ALT7: rd_val = rx_lvl8;
            SEL_DLL: rd_val = div_zero ? REV_CODE : dll_ff;
            SEL_DLM: rd_val = div_zero ? DEV_CODE : dlm_ff;
            SEL_DLD: rd_val = {4'h0, dld_ff};
            SEL_TRG: rd_val = feature_control_ff[FEATURE_CONTROL_MODE] ? rx_lvl8 : tx_lvl8;
            SEL_FEATURE_CONTROL: rd_val = feature_control_ff;
            SEL_EFR: rd_val = efr_ff;
            SEL_FLOW: rd_val = flow_ch_ff[addr[1:0]];
            default: rd_val = 8'h00;
        endcase
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            data_out <= RST_BYTE;
            data_oe <= 1'b0;
        end else begin
            data_oe <= !cs_n && !rd_n;
            if (rd_stb) begin
                data_out <= rd_val;
            end
        end
    end
    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_int_raise: assert property (pend != 5'h00 |=> int_out)
        else $error("interrupt not raised");
    a_int_drop: assert property (pend == 5'h00 |=> !int_out)
        else $error("interrupt not withdrawn");
    a_rx_trig: assert property (fifo_en_ff && ier_ff[0] && rx_lvl8 >= rx_trig |=> int_out)
        else $error("trigger level did not interrupt");
    a_rx_below: assert property (fifo_en_ff && rx_lvl8 < rx_trig |-> !pend[2])
        else $error("receive interrupt held below trigger");
    a_dr_set: assert property (rx_push && !rx_flush |=> lsr_val[0])
        else $error("data ready not set");
    a_ovr_irq: assert property (rx_overrun && ier_ff[2] && !wr_stb |-> ##2 int_out)
        else $error("overrun did not interrupt");
    a_thr_arm: assert property (tx_arm && tx_cond |=> tx_irq_ff)
        else $error("enable with empty holding did not interrupt");
    a_lsr_clr: assert property (lsr_rd && !rx_overrun |=> !overrun_ff)
        else $error("line status read did not clear overrun");
    a_enh_lock: assert property (wr_stb && sel == SEL_IRQEN && !enh |=>
        ier_ff[7:4] == $past(ier_ff[7:4]))
        else $error("upper enables written while locked");
    a_msr_irq: assert property (modem_delta != 4'h0 && ier_ff[3] && !wr_stb |-> ##2 int_out)
        else $error("modem change did not interrupt");
endmodule : uart_host_regs
`default_nettype wire

/* File: hdl/uart_regs_pkg.sv */
// Constants, types and register map of one UART channel's host register block.
// Assumes a host bus with a 3-bit register address and byte-wide data.
// Behaviour
// - Enable bits mask each interrupt source; timeout shares bit 0 with receive.
// - Receive interrupt follows FIFO level against trigger.
// - Status code clears at once below trigger; int_out is registered and drops one cycle after the code.
// - Data ready sets on push, clears when empty.
// - All four enables clear gives polled operation.
// - Overrun bit flags possibly invalid FIFO data.
// - Error bits describe the head character.
// - Holding empty and transmitter empty bits.
// - Global error bit while errored characters stored.
// - Bit 0 enables receive data ready interrupt.
// - Bit 1 enables transmit ready interrupt.
// - Enabling with holding empty interrupts at once.
// - Bit 2 enables interrupt on line errors.
// - Overrun interrupts immediately on reception.
// - Other errors interrupt on read or immediately.
// - Bit 3 enables the modem status interrupt.
// - Enhanced bits need enhanced function bit 4.
// - Reading line status clears its interrupt.
// - Receive timeout after four characters plus twelve bits.
// - Any modem delta bit raises the modem interrupt.
package uart_regs_pkg;
    localparam logic [2:0] ADR_DATA = 3'h0;
    localparam logic [2:0] ADR_IRQEN = 3'h1;
    localparam logic [2:0] ADR_ISR = 3'h2;
    localparam logic [2:0] ADR_LCR = 3'h3;
    localparam logic [2:0] ADR_MCR = 3'h4;
    localparam logic [2:0] ADR_LSR = 3'h5;
    localparam logic [2:0] ADR_MSR = 3'h6;
    localparam logic [2:0] ADR_SPR = 3'h7;
    localparam logic [2:0] ADR_TRG = 3'h0;
    localparam logic [2:0] ADR_FEATURE_CONTROL = 3'h1;
    localparam logic [2:0] ADR_EFR = 3'h2;
    localparam logic [2:0] ADR_FLOW_BASE = 3'h4;
    localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
    localparam int LCR_DLAB = 7;
    localparam int EFR_ENH = 4;
    localparam int FEATURE_CONTROL_MODE = 7;
    localparam int FEATURE_CONTROL_SWAP = 6;
    localparam int ENHANCED_MODE_SELECT_IMM = 6;
    localparam int FCR_EN = 0;
    localparam int FCR_RXRST = 1;
    localparam int FCR_TXRST = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] ISR_LINE = 6'h06;
    localparam logic [5:0] ISR_TOUT = 6'h0c;
    localparam logic [5:0] ISR_RX_DATA_READY_IRQ = 6'h04;
    localparam logic [5:0] ISR_TXRDY = 6'h02;
    localparam logic [5:0] ISR_MODEM = 6'h00;
    localparam logic [5:0] ISR_NONE = 6'h01;
    localparam logic [7:0] TRIG_L0 = 8'h01;
    localparam logic [7:0] TRIG_L1 = 8'h08;
    localparam logic [7:0] TRIG_L2 = 8'h10;
    localparam logic [7:0] TRIG_L3 = 8'h1c;
    localparam logic [5:0] TOUT_CHARS = 6'h04;
    localparam logic [5:0] TOUT_BITS = 6'h0c;
    localparam logic [19:0] BAUD_OVERSAMPLE = 20'h00010;
    localparam int FIFO_DEPTH = 32;
    typedef struct packed {
        logic brk;
        logic frm;
        logic par;
        logic [7:0] data;
    } rx_char_t;
    typedef enum {SEL_NONE, SEL_DATA, SEL_IRQEN, SEL_ISR, SEL_LCR, SEL_MCR, SEL_LSR,
        SEL_MSR, SEL_SPR, SEL_ALT7, SEL_DLL, SEL_DLM, SEL_DLD, SEL_TRG, SEL_FEATURE_CONTROL,
        SEL_EFR, SEL_FLOW} sel_t;
endpackage : uart_regs_pkg

/* File: test/host_model.sv */
// Host processor model: one byte access on the strobe bus for each call.
// Assumes each call starts just after a falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // Bus
    input wire logic core_clk,
    output logic cs_n = 1'b1,
    output logic rd_n = 1'b1,
    output logic wr_n = 1'b1,
    output logic [2:0] addr = 3'h0,
    output logic [7:0] data_in = 8'h00,
    input wire logic [7:0] data_out
);
    // Strobes stay low until the answer edge has passed, so no access is taken twice.
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
        output logic [7:0] q);
        {cs_n, rd_n, wr_n, addr, data_in} = {1'b0, w, !w, a, d};
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        q = data_out;
        {cs_n, rd_n, wr_n, data_in} = {3'b111, ~d};
        @(negedge core_clk);
    endtask : acc
endmodule : host_model
`default_nettype wire

/* File: test/tb_uart_host_regs.sv */
// Bench of the host register block: bus through host_model, receiver and modem here.
// Assumes read data appears one cycle after the strobe is taken.
`timescale 1ns/1ns
`default_nettype none
module tb_uart_host_regs import uart_regs_pkg::*;;
    logic core_clk = 1'b0, nrst = 1'b0, rx_valid = 1'b0, tx_ready = 1'b0, tx_shift_busy = 1'b0;
    logic cs_n, rd_n, wr_n, data_oe, int_out, tx_valid;
    logic [2:0] addr;
    logic [7:0] data_in, data_out, tx_data, q;
    logic [3:0] modem_delta = 4'h0, modem_lines = 4'ha;
    rx_char_t rx_char = '0;
    logic [31:0] lf = 32'h1646;
    logic [7:0] exp_q[$];
    int error_cnt = 0, n_compared = 0, cyc = 0;
    always #5 core_clk = ~core_clk;
    uart_host_regs i_uart_host_regs (.core_clk, .nrst, .cs_n, .rd_n, .wr_n, .addr, .data_in,
        .data_out, .data_oe, .int_out, .rx_valid, .rx_char, .tx_valid, .tx_data, .tx_ready,
        .tx_shift_busy, .modem_delta, .modem_lines);
    host_model host (.core_clk, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out);
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e) $display("FAIL %s expected %h seen %h", n, e, s);
        if (s !== e) error_cnt++;
    endtask : chk8
    task automatic rdc(input string n, input logic [2:0] a, input logic [7:0] e);
        host.acc(1'b0, a, 8'h00, q);
        chk8(n, e, q);
    endtask : rdc
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host.acc(1'b1, a, d, q);
    endtask : wr
    task automatic wint(input logic e);
        for (int k = 0; k < 8 && int_out !== e; k++) @(negedge core_clk);
        chk8("int_out", {7'h00, e}, {7'h00, int_out});
    endtask : wint
    // A refused character is not queued, since the serial line cannot be stalled.
    task automatic push(input logic [2:0] f, input logic keep);
        lf = nx(lf);
        if (keep) exp_q.push_back(lf[7:0]);
        {rx_valid, rx_char} = {1'b1, f, lf[7:0]};
        @(negedge core_clk);
        rx_valid = 1'b0;
        @(negedge core_clk);
    endtask : push
    task automatic conclude(input logic late);
        error_cnt += late;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) conclude(1'b1);
    end
    initial begin
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        // A zero divisor would stop the bit tick, so the receive timeout would never fire.
        wr(ADR_LCR, 8'h80);
        wr(ADR_DATA, 8'h01);
        wr(ADR_LCR, 8'h00);
        wr(ADR_IRQEN, 8'hf0);
        rdc("ier", ADR_IRQEN, 8'h00);
        wr(ADR_ISR, 8'h41);
        wr(ADR_IRQEN, 8'h02);
        wint(1'b1);
        rdc("isr", ADR_ISR, {2'b11, ISR_TXRDY});
        wr(ADR_IRQEN, 8'h01);
        repeat (8) push(3'h0, 1'b1);
        wint(1'b1);
        rdc("isr", ADR_ISR, {2'b11, ISR_RX_DATA_READY_IRQ});
        rdc("rhr", ADR_DATA, exp_q.pop_front());
        wint(1'b0);
        wr(ADR_IRQEN, 8'h04);
        repeat (25) push(3'h0, 1'b1);
        push(3'h0, 1'b0);
        wint(1'b1);
        rdc("lsr", ADR_LSR, 8'h63);
        wint(1'b0);
        while (exp_q.size() > 0) rdc("rhr", ADR_DATA, exp_q.pop_front());
        push(3'h1, 1'b1);
        rdc("lsr", ADR_LSR, 8'he5);
        wint(1'b0);
        rdc("rhr", ADR_DATA, exp_q.pop_front());
        wint(1'b1);
        rdc("lsr", ADR_LSR, 8'h60);
        wint(1'b0);
        wr(ADR_IRQEN, 8'h08);
        modem_delta = 4'h1;
        @(negedge core_clk);
        modem_delta = 4'h0;
        wint(1'b1);
        rdc("msr", ADR_MSR, 8'ha1);
        wint(1'b0);
        wr(ADR_DATA, 8'h5a);
        chk8("tx_valid", 8'h01, {7'h00, tx_valid});
        chk8("tx_data", 8'h5a, tx_data);
        rdc("lsr", ADR_LSR, 8'h20);
        tx_ready = 1'b1;
        @(negedge core_clk);
        tx_ready = 1'b0;
        chk8("tx_valid", 8'h00, {7'h00, tx_valid});
        rdc("lsr", ADR_LSR, 8'h60);
        conclude(1'b0);
    end
endmodule : tb_uart_host_regs
`default_nettype wire
